// ---- core/mas_conv_timer.sv ----
// per-conversion timer, length picked by the sample speed
`timescale 1ns/1ps
`default_nettype none
module mas_conv_timer (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // control
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic [1:0] speed,
  // result
  output logic            done
);

  typedef struct packed {
    logic [mas_pkg::CONV_W-1:0] cnt;
    logic                       busy;
    logic                       done;
  } mas_timer_t;

  mas_timer_t s;
  mas_timer_t n;

  function automatic logic [mas_pkg::CONV_W-1:0] convCycles(input logic [1:0] sp);
    case (sp)
      2'h0:    return mas_pkg::CONV_CYC_0;
      2'h1:    return mas_pkg::CONV_CYC_1;
      2'h2:    return mas_pkg::CONV_CYC_2;
      default: return mas_pkg::CONV_CYC_3;
    endcase
  endfunction

  always_comb begin
    n = s;
    n.done = 1'b0;
    if (abort) begin
      n.busy = 1'b0;
    end else if (start) begin
      n.busy = 1'b1;
      n.cnt  = convCycles(speed) - 8'h01;
    end else if (s.busy) begin
      if (s.cnt == 8'h00) begin
        n.busy = 1'b0;
        n.done = 1'b1;
      end else begin
        n.cnt = s.cnt - 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign done = s.done;

endmodule
`default_nettype wire

// ---- core/mas_irq_pulse.sv ----
// fixed-length active-low interrupt pulse generator
`timescale 1ns/1ps
`default_nettype none
module mas_irq_pulse #(
  parameter int PULSE_CYC = mas_pkg::IRQ_PULSE_CYC
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic resetn,
  // event in
  input  wire logic trigger,
  // pin out
  output logic      irqN
);

  typedef struct packed {
    logic [mas_pkg::IRQ_CNT_W-1:0] cnt;
    logic                          irqN;
  } mas_pulse_t;

  mas_pulse_t s;
  mas_pulse_t n;

  always_comb begin
    n = s;
    // fixed-length low pulse
    // retrigger restarts the full pulse
    if (trigger) begin
      n.irqN = 1'b0;
      n.cnt  = 13'(PULSE_CYC - 1);
    end else if (!s.irqN) begin
      if (s.cnt == 13'h0000) begin
        n.irqN = 1'b1;
      end else begin
        n.cnt = s.cnt - 13'h0001;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s <= '{cnt: 13'h0000, irqN: 1'b1};
    end else begin
      s <= n;
    end
  end

  assign irqN = s.irqN;

endmodule
`default_nettype wire

// ---- core/mas_pkg.sv ----
// shared constants and types for the monitor converter sequencer
package mas_pkg;

  // widths
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 16;
  localparam int NUM_CH    = 8;
  localparam int CH_W      = 3;
  localparam int CONV_W    = 8;
  localparam int IRQ_CNT_W = 13;

  // register offsets
  localparam logic [7:0] ADDR_CONV_CTRL = 8'h15;
  localparam logic [7:0] ADDR_CH_DIS    = 8'h16;
  localparam logic [7:0] ADDR_RESULT0   = 8'h17;
  localparam logic [7:0] ADDR_RESULT7   = 8'h1E;
  localparam logic [7:0] ADDR_DONE      = 8'h25;

  // field positions
  localparam int CTRL_EN_BIT     = 7;
  localparam int CTRL_RATE_BIT   = 6;
  localparam int CTRL_SAMPLE_LSB = 4;
  localparam int DONE_STAT_BIT   = 0;
  localparam int DONE_FLAG_BIT   = 1;
  localparam int DONE_MASK_BIT   = 2;

  // reset values and encodings
  localparam logic       RATE_CONT      = 1'b0;
  localparam logic       RATE_ONESHOT   = 1'b1;
  localparam logic [1:0] SAMPLE_RESET   = 2'h0;
  localparam logic [7:0] CH_DIS_RESET   = 8'h00;
  localparam logic       MASK_RESET     = 1'b0;
  localparam logic [15:0] RESULT_RESET  = 16'h0000;

  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int CONV_NS_0     = 4000;
  localparam int CONV_NS_1     = 2000;
  localparam int CONV_NS_2     = 1000;
  localparam int CONV_NS_3     = 480;
  localparam logic [7:0] CONV_CYC_0 = 8'(CONV_NS_0 / CLK_PERIOD_NS);
  localparam logic [7:0] CONV_CYC_1 = 8'(CONV_NS_1 / CLK_PERIOD_NS);
  localparam logic [7:0] CONV_CYC_2 = 8'(CONV_NS_2 / CLK_PERIOD_NS);
  localparam logic [7:0] CONV_CYC_3 = 8'(CONV_NS_3 / CLK_PERIOD_NS);
  localparam int IRQ_PULSE_US  = 256;
  localparam int IRQ_PULSE_CYC = IRQ_PULSE_US * 1000 / CLK_PERIOD_NS;

  typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_PAUSE, ST_WAIT} mas_state_t;

endpackage

// ---- core/mas_sequencer.sv ----
// monitor converter sequencer: control, channel walk, results, done event
// Function
// - 16-bit results; conversions run only while the enable bit is set.
// - rate bit picks continuous or one-shot; one-shot end clears enable.
// - no input and no battery present: skip, keep results, clear enable, no irq.
// - enable with all channels off clears enable; same in one-shot when all go off.
// - mode change pauses conversion; resume from the interrupted channel.
// - two-bit sample speed sets the per-conversion time.
// - disabled channels skipped; their result keeps last value, zero from reset.
// - channel disabled mid-measurement finishes, then is skipped afterwards.
// - continuous with all off stays active, restarts when any channel enabled.
// - one-shot completion sets done status and flag, pulses irq unless masked.
// - continuous: done status reads zero, done flag untouched.
// - faults never stop conversion; only the host clearing enable does.
// - adapter plug-in pauses conversion until source detection completes.
// - host writing enable zero stops at once; results hold last readings.
// - switching rate to one-shot stops after the whole current cycle.
// - disabling all channels in one-shot stops after the current measurement.
// - each interrupt event is a fixed 256 us active-low pulse.
// - done flag clears on host read; needs a new status rise to set.
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module mas_sequencer #(
  parameter int IRQ_PULSE_CYC = mas_pkg::IRQ_PULSE_CYC
) (
  // clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       resetn,
  // register port
  input  wire logic [mas_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [mas_pkg::DATA_W-1:0] regWrData,
  input  wire logic                       regWr,
  input  wire logic                       regRd,
  output logic      [mas_pkg::DATA_W-1:0] regRdData,
  // device state
  input  wire logic                       inputPresentLevel,
  input  wire logic                       batteryPresentLevel,
  input  wire logic                       modeChangeBusy,
  input  wire logic                       inputHighImpedance,
  input  wire logic                       reverseOutputEnable,
  input  wire logic                       adapterAttached,
  input  wire logic                       srcDetectDone,
  // analog converter
  input  wire logic [mas_pkg::DATA_W-1:0] adcData,
  output logic                            adcActive,
  output logic      [mas_pkg::CH_W-1:0]   adcChannel,
  output logic      [1:0]                 adcSampleSpeed,
  // host pin
  output logic                            hostIrqN
);

  typedef struct packed {
    mas_pkg::mas_state_t                            state;
    logic                                           en;
    logic                                           rate;
    logic [1:0]                                     sample;
    logic [mas_pkg::NUM_CH-1:0]                     chDis;
    logic                                           doneStat;
    logic                                           doneFlag;
    logic                                           doneMask;
    logic [mas_pkg::CH_W-1:0]                       chan;
    logic                                           detectPend;
    logic                                           adapterQ;
    logic                                           hizQ;
    logic                                           otgQ;
    logic [mas_pkg::NUM_CH-1:0][mas_pkg::DATA_W-1:0] result;
    logic [mas_pkg::DATA_W-1:0]                     rdData;
    logic                                           active;
    logic                                           timerStart;
    logic                                           timerAbort;
    logic                                           irqTrig;
  } mas_seq_t;

  mas_seq_t s;
  mas_seq_t n;
  logic     timerDone;

  // first enabled channel at or above from: {found, index}
  function automatic logic [3:0] firstEnabled(input logic [7:0] dis, input logic [3:0] from);
    logic [3:0] r;
    r = 4'h0;
    for (int i = mas_pkg::NUM_CH - 1; i >= 0; i--) begin
      if (!dis[i] && (4'(i) >= from)) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic isResult(input logic [7:0] a);
    return (a >= mas_pkg::ADDR_RESULT0) && (a <= mas_pkg::ADDR_RESULT7);
  endfunction

  mas_conv_timer u_timer (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .start   (s.timerStart),
    .abort   (s.timerAbort),
    .speed   (s.sample),
    .done    (timerDone)
  );

  mas_irq_pulse #(
    .PULSE_CYC (IRQ_PULSE_CYC)
  ) u_irq (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .trigger (s.irqTrig),
    .irqN    (hostIrqN)
  );

  logic       plug;
  logic       pause;
  logic       hwClr;
  logic       goNext;
  logic       flagSet;
  logic       ctrlWr;
  logic [3:0] f;
  logic [7:0] resIdx;

  always_comb begin
    n            = s;
    n.timerStart = 1'b0;
    n.timerAbort = 1'b0;
    n.irqTrig    = 1'b0;
    hwClr        = 1'b0;
    goNext       = 1'b0;
    flagSet      = 1'b0;
    f            = 4'h0;
    resIdx       = regAddr - mas_pkg::ADDR_RESULT0;
    ctrlWr       = regWr && (regAddr == mas_pkg::ADDR_CONV_CTRL);

    // busy level, pending detection and mode change edges pause the walk
    plug       = adapterAttached & ~s.adapterQ;
    n.adapterQ = adapterAttached;
    n.hizQ     = inputHighImpedance;
    n.otgQ     = reverseOutputEnable;
    // held off until source detection done
    n.detectPend = plug | (s.detectPend & ~srcDetectDone);
    pause = modeChangeBusy | s.detectPend | plug
          | (inputHighImpedance & ~s.hizQ) | (reverseOutputEnable & ~s.otgQ);

    // register writes
    if (ctrlWr) begin
      n.en     = regWrData[mas_pkg::CTRL_EN_BIT];
      n.rate   = regWrData[mas_pkg::CTRL_RATE_BIT];
      n.sample = regWrData[mas_pkg::CTRL_SAMPLE_LSB +: 2];
    end
    if (regWr && (regAddr == mas_pkg::ADDR_CH_DIS)) begin
      n.chDis = regWrData[mas_pkg::NUM_CH-1:0];
    end
    if (regWr && (regAddr == mas_pkg::ADDR_DONE)) begin
      n.doneMask = regWrData[mas_pkg::DONE_MASK_BIT];
    end

    // faults are deliberately not inputs here
    // only enable stops the walk
    case (s.state)
      mas_pkg::ST_IDLE: begin
        n.active = 1'b0;
        if (s.en) begin
          f = firstEnabled(s.chDis, 4'h0);
          if (!(inputPresentLevel || batteryPresentLevel)) begin
            hwClr = 1'b1;
          end else if (!f[3]) begin
            hwClr = 1'b1;
          end else begin
            n.chan     = f[2:0];
            n.doneStat = 1'b0;
            n.active   = 1'b1;
            goNext     = 1'b1;
          end
        end
      end
      mas_pkg::ST_CONV: begin
        if (!s.en) begin
          n.state      = mas_pkg::ST_IDLE;
          n.active     = 1'b0;
          n.timerAbort = 1'b1;
        end else if (timerDone) begin
          n.result[s.chan] = adcData;
          // live mask only steers the next pick
          f = firstEnabled(s.chDis, {1'b0, s.chan} + 4'h1);
          if (f[3]) begin
            n.chan = f[2:0];
            goNext = 1'b1;
          end else if (s.rate == mas_pkg::RATE_ONESHOT) begin
            hwClr      = 1'b1;
            n.state    = mas_pkg::ST_IDLE;
            n.active   = 1'b0;
            n.doneStat = 1'b1;
            flagSet    = ~s.doneStat;
            n.irqTrig  = ~s.doneMask;
          end else begin
            f = firstEnabled(s.chDis, 4'h0);
            if (f[3]) begin
              n.chan = f[2:0];
              goNext = 1'b1;
            // all off: wait in ST_WAIT, still active, after this measurement
            end else begin
              n.state = mas_pkg::ST_WAIT;
            end
          end
        end else if (pause) begin
          n.state      = mas_pkg::ST_PAUSE;
          n.timerAbort = 1'b1;
        end
      end
      mas_pkg::ST_WAIT: begin
        f = firstEnabled(s.chDis, 4'h0);
        if (!s.en) begin
          n.state  = mas_pkg::ST_IDLE;
          n.active = 1'b0;
        // one-shot with all off clears enable
        end else if (s.rate == mas_pkg::RATE_ONESHOT) begin
          hwClr    = 1'b1;
          n.state  = mas_pkg::ST_IDLE;
          n.active = 1'b0;
        // resume as soon as a channel returns
        end else if (f[3]) begin
          n.chan = f[2:0];
          goNext = 1'b1;
        end
      end
      mas_pkg::ST_PAUSE: begin
        if (!s.en) begin
          n.state  = mas_pkg::ST_IDLE;
          n.active = 1'b0;
        end else if (!pause) begin
          n.state      = mas_pkg::ST_CONV;
          n.timerStart = 1'b1;
        end
      end
      default: begin
        n.state  = mas_pkg::ST_IDLE;
        n.active = 1'b0;
      end
    endcase

    // next conversion, unless a pause holds it
    if (goNext) begin
      if (pause) begin
        n.state = mas_pkg::ST_PAUSE;
      end else begin
        n.state      = mas_pkg::ST_CONV;
        n.timerStart = 1'b1;
      end
    end

    // hardware clear loses to a same-cycle host write
    if (hwClr && !ctrlWr) begin
      n.en = 1'b0;
    end

    if (s.rate == mas_pkg::RATE_CONT) begin
      n.doneStat = 1'b0;
    end

    // read clears flag, new set wins
    if (flagSet) begin
      n.doneFlag = 1'b1;
    end else if (regRd && (regAddr == mas_pkg::ADDR_DONE)) begin
      n.doneFlag = 1'b0;
    end

    // read data lives one cycle only
    n.rdData = '0;
    if (regRd) begin
      if (regAddr == mas_pkg::ADDR_CONV_CTRL) begin
        // enable readable to confirm a run
        n.rdData[mas_pkg::CTRL_EN_BIT]          = s.en;
        n.rdData[mas_pkg::CTRL_RATE_BIT]        = s.rate;
        n.rdData[mas_pkg::CTRL_SAMPLE_LSB +: 2] = s.sample;
      end else if (regAddr == mas_pkg::ADDR_CH_DIS) begin
        n.rdData[mas_pkg::NUM_CH-1:0] = s.chDis;
      end else if (regAddr == mas_pkg::ADDR_DONE) begin
        n.rdData[mas_pkg::DONE_STAT_BIT] = s.doneStat;
        n.rdData[mas_pkg::DONE_FLAG_BIT] = s.doneFlag;
        n.rdData[mas_pkg::DONE_MASK_BIT] = s.doneMask;
      end else if (isResult(regAddr)) begin
        n.rdData = s.result[resIdx[mas_pkg::CH_W-1:0]];
      end
    end
  end

  // results zero from reset, held when skipped
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s            <= '0;
      s.state      <= mas_pkg::ST_IDLE;
      s.rate       <= mas_pkg::RATE_CONT;
      s.sample     <= mas_pkg::SAMPLE_RESET;
      s.chDis      <= mas_pkg::CH_DIS_RESET;
      s.doneMask   <= mas_pkg::MASK_RESET;
      s.result     <= {mas_pkg::NUM_CH{mas_pkg::RESULT_RESET}};
    end else begin
      s <= n;
    end
  end

  assign regRdData      = s.rdData;
  assign adcActive      = s.active;
  assign adcChannel     = s.chan;
  assign adcSampleSpeed = s.sample;

endmodule
`default_nettype wire

// ---- verification/mas_adc_model.sv ----
// behavioural analog converter feeding the sequencer
`timescale 1ns/1ps
`default_nettype none
module mas_adc_model (
  // clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     resetn,
  // converter control
  input  wire logic                     adcActive,
  input  wire logic [mas_pkg::CH_W-1:0] adcChannel,
  input  wire logic [15:0]              base,
  // sample out
  output logic      [15:0]              adcData
);
  // idle output toggles so a stale sample never matches
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      adcData <= 16'h0000;
    end else if (adcActive) begin
      adcData <= base | 16'(adcChannel);
    end else begin
      adcData <= ~adcData;
    end
  end
endmodule
`default_nettype wire

// ---- verification/mas_sequencer_assertions.sv ----
// port-level assertion checker for the monitor converter sequencer
`timescale 1ns/1ps
`default_nettype none
module mas_sequencer_checker #(
  parameter int IRQ_PULSE_CYC = mas_pkg::IRQ_PULSE_CYC
) (
  // clock and reset
  input wire logic                       ref_clk,
  input wire logic                       resetn,
  // register port
  input wire logic [mas_pkg::ADDR_W-1:0] regAddr,
  input wire logic [mas_pkg::DATA_W-1:0] regWrData,
  input wire logic                       regWr,
  input wire logic                       regRd,
  input wire logic [mas_pkg::DATA_W-1:0] regRdData,
  // device state
  input wire logic                       inputPresentLevel,
  input wire logic                       batteryPresentLevel,
  input wire logic                       modeChangeBusy,
  input wire logic                       inputHighImpedance,
  input wire logic                       reverseOutputEnable,
  input wire logic                       adapterAttached,
  input wire logic                       srcDetectDone,
  // converter and pin
  input wire logic [mas_pkg::DATA_W-1:0] adcData,
  input wire logic                       adcActive,
  input wire logic [mas_pkg::CH_W-1:0]   adcChannel,
  input wire logic [1:0]                 adcSampleSpeed,
  input wire logic                       hostIrqN
);
  wire       wrCtl   = regWr && regAddr == mas_pkg::ADDR_CONV_CTRL;
  wire       rdDone  = regRd && regAddr == mas_pkg::ADDR_DONE;
  wire       noPwr   = !inputPresentLevel && !batteryPresentLevel;
  wire [1:0] wrSpeed = regWrData[5:4];
  logic [7:0]  sinceEn_q;
  logic [15:0] lowCnt_q;
  // saturating counter, so a long idle never wraps into a false start window
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sinceEn_q <= 8'hFF;
      lowCnt_q  <= 16'h0000;
    end else begin
      sinceEn_q <= (wrCtl && regWrData[7]) ? 8'h00 :
                   (sinceEn_q == 8'hFF) ? sinceEn_q : sinceEn_q + 8'h01;
      lowCnt_q  <= hostIrqN ? 16'h0000 : lowCnt_q + 16'h0001;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  read_idle_zero_a: assert property (!$past(regRd) |-> regRdData == 16'h0000)
    else $error("read data not zero outside read slot");
  start_after_en_a: assert property ($rose(adcActive) |-> sinceEn_q <= 8'h04)
    else $error("converter started without enable write");
  no_power_skip_a: assert property (wrCtl && regWrData[7] && noPwr && !adcActive
    ##1 noPwr[*4] |-> !adcActive)
    else $error("converter ran with no supply present");
  pause_hold_a: assert property (modeChangeBusy[*3] |-> $stable(adcChannel))
    else $error("channel moved during mode change");
  speed_follow_a: assert property (wrCtl ##1 !wrCtl |-> ##1 adcSampleSpeed == $past(wrSpeed, 2))
    else $error("sample speed output differs from field");
  stop_now_a: assert property (wrCtl && !regWrData[7] |-> ##[1:2] !adcActive)
    else $error("converter kept running after enable cleared");
  irq_width_a: assert property ($rose(hostIrqN) |-> lowCnt_q == 16'(IRQ_PULSE_CYC))
    else $error("interrupt pulse has wrong width");
  flag_clear_a: assert property (rdDone ##2 rdDone |=> !regRdData[mas_pkg::DONE_FLAG_BIT])
    else $error("done flag not cleared by read");
  cover property ($fell(hostIrqN));
  cover property (wrCtl ##[1:4] $rose(adcActive));
  cover property (modeChangeBusy && adcActive);
endmodule
bind mas_sequencer mas_sequencer_checker #(.IRQ_PULSE_CYC(IRQ_PULSE_CYC)) u_chk (
  .ref_clk(ref_clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
  .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
  .inputPresentLevel(inputPresentLevel), .batteryPresentLevel(batteryPresentLevel),
  .modeChangeBusy(modeChangeBusy), .inputHighImpedance(inputHighImpedance),
  .reverseOutputEnable(reverseOutputEnable), .adapterAttached(adapterAttached),
  .srcDetectDone(srcDetectDone), .adcData(adcData), .adcActive(adcActive),
  .adcChannel(adcChannel), .adcSampleSpeed(adcSampleSpeed), .hostIrqN(hostIrqN)
);
`default_nettype wire

// ---- verification/tb.sv ----
// self-checking bench for the monitor converter sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        ref_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [15:0] regWrData = 16'h0000;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic        inPres = 1'b1;
  logic        batPres = 1'b1;
  logic [3:0]  pauseIn = 4'h0;
  logic        srcDone = 1'b0;
  logic [15:0] base = 16'hA500;
  logic [15:0] regRdData;
  logic [15:0] adcData;
  logic        adcActive;
  logic [2:0]  adcChannel;
  logic [1:0]  adcSampleSpeed;
  logic        hostIrqN;
  logic [2:0]  ch;
  int          n_errors = 0;
  int          checks = 0;
  int          irqFalls = 0;
  int          convCnt = 0;
  logic [7:0]  convCyc [4] = '{mas_pkg::CONV_CYC_0, mas_pkg::CONV_CYC_1,
                               mas_pkg::CONV_CYC_2, mas_pkg::CONV_CYC_3};
  mas_sequencer #(.IRQ_PULSE_CYC(16)) u_dut (
    .ref_clk(ref_clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .inputPresentLevel(inPres), .batteryPresentLevel(batPres),
    .modeChangeBusy(pauseIn[0]), .inputHighImpedance(pauseIn[1]),
    .reverseOutputEnable(pauseIn[2]), .adapterAttached(pauseIn[3]),
    .srcDetectDone(srcDone), .adcData(adcData), .adcActive(adcActive),
    .adcChannel(adcChannel), .adcSampleSpeed(adcSampleSpeed), .hostIrqN(hostIrqN)
  );
  mas_adc_model u_adc (
    .ref_clk(ref_clk), .resetn(resetn), .adcActive(adcActive),
    .adcChannel(adcChannel), .base(base), .adcData(adcData)
  );
  always #20 ref_clk = ~ref_clk;
  always @(negedge hostIrqN) irqFalls++;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= v;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string what);
    @(posedge ref_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1;
    chk(regRdData, exp, what);
  endtask
  task automatic idle();
    cyc(4);
    for (int i = 0; i < 3000 && adcActive !== 1'b0; i++) cyc(1);
    chk(16'(adcActive), 16'h0000, "converter still active");
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // long enough for every test several times over
  initial begin
    #(40 * 20000);
    n_errors++;
    $display("wrong value at %0t: watchdog expired", $time);
    wrap_up();
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(mas_pkg::ADDR_CONV_CTRL, 16'h0000, "ctrl reset");
    rd(mas_pkg::ADDR_CH_DIS, 16'h0000, "disable reset");
    rd(mas_pkg::ADDR_RESULT7, 16'h0000, "result reset");
    rd(mas_pkg::ADDR_DONE, 16'h0000, "done reset");
    rd(8'h40, 16'h0000, "unmapped read");
    $display("test reset done");
    wr(mas_pkg::ADDR_CH_DIS, 16'h00F5);
    wr(mas_pkg::ADDR_CONV_CTRL, 16'h00F0);
    rd(mas_pkg::ADDR_CONV_CTRL, 16'h00F0, "enable read back");
    chk(16'(adcSampleSpeed), 16'h0003, "sample speed");
    idle();
    rd(mas_pkg::ADDR_RESULT0 + 8'h01, 16'hA501, "result ch1");
    rd(mas_pkg::ADDR_RESULT0 + 8'h03, 16'hA503, "result ch3");
    rd(mas_pkg::ADDR_RESULT0, 16'h0000, "skipped ch0");
    rd(mas_pkg::ADDR_CONV_CTRL, 16'h0070, "one-shot end");
    chk(16'(irqFalls), 16'h0001, "done irq");
    rd(mas_pkg::ADDR_DONE, 16'h0003, "done set");
    rd(mas_pkg::ADDR_DONE, 16'h0001, "flag after read");
    $display("test one-shot done");
    @(posedge ref_clk);
    inPres <= 1'b0;
    batPres <= 1'b0;
    wr(mas_pkg::ADDR_CONV_CTRL, 16'h00F0);
    cyc(6);
    rd(mas_pkg::ADDR_CONV_CTRL, 16'h0070, "no supply enable");
    rd(mas_pkg::ADDR_RESULT0 + 8'h01, 16'hA501, "no supply result");
    chk(16'(irqFalls), 16'h0001, "no supply irq");
    @(posedge ref_clk);
    batPres <= 1'b1;
    wr(mas_pkg::ADDR_CH_DIS, 16'h00FF);
    wr(mas_pkg::ADDR_CONV_CTRL, 16'h00B0);
    cyc(6);
    rd(mas_pkg::ADDR_CONV_CTRL, 16'h0030, "all off enable");
    chk(16'(irqFalls), 16'h0001, "all off irq");
    $display("test refusals done");
    wr(mas_pkg::ADDR_DONE, 16'h0004);
    wr(mas_pkg::ADDR_CH_DIS, 16'h0000);
    wr(mas_pkg::ADDR_CONV_CTRL, 16'h00B0);
    cyc(6);
    // busy, high impedance, reverse output, adapter in turn
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk);
      pauseIn[k] <= 1'b1;
      cyc(3);
      ch = adcChannel;
      cyc(40);
      @(posedge ref_clk);
      pauseIn[k] <= 1'b0;
      srcDone <= (k == 3);
      @(posedge ref_clk);
      srcDone <= 1'b0;
      #1;
      if (k == 0 || k == 3) chk(16'(adcChannel), 16'(ch), "resume channel");
      cyc(30);
      chk(16'(adcActive), 16'h0001, "walk resumed");
      if (k == 0 || k == 3) chk(16'(adcChannel != ch), 16'h0001, "walk moved on");
    end
    rd(mas_pkg::ADDR_DONE, 16'h0004, "continuous done");
    wr(mas_pkg::ADDR_CH_DIS, 16'h00FF);
    cyc(30);
    chk(16'(adcActive), 16'h0001, "waiting active");
    rd(mas_pkg::ADDR_CONV_CTRL, 16'h00B0, "waiting enable");
    wr(mas_pkg::ADDR_CH_DIS, 16'h00FD);
    cyc(30);
    chk(16'(adcChannel), 16'h0001, "restart on ch1");
    wr(mas_pkg::ADDR_CONV_CTRL, 16'h00F0);
    idle();
    rd(mas_pkg::ADDR_CONV_CTRL, 16'h0070, "graceful stop");
    rd(mas_pkg::ADDR_DONE, 16'h0007, "masked done");
    chk(16'(irqFalls), 16'h0001, "masked irq");
    wr(mas_pkg::ADDR_CONV_CTRL, 16'h00B0);
    cyc(8);
    wr(mas_pkg::ADDR_CONV_CTRL, 16'h0030);
    cyc(2);
    chk(16'(adcActive), 16'h0000, "host stop");
    rd(mas_pkg::ADDR_RESULT0 + 8'h01, 16'hA501, "kept result");
    $display("test continuous done");
    @(posedge ref_clk);
    base <= 16'h3C00;
    wr(mas_pkg::ADDR_CH_DIS, 16'h0000);
    wr(mas_pkg::ADDR_CONV_CTRL, 16'h00F0);
    cyc(6);
    wr(mas_pkg::ADDR_CH_DIS, 16'h00FF);
    idle();
    rd(mas_pkg::ADDR_RESULT0, 16'h3C00, "finished ch0");
    rd(mas_pkg::ADDR_RESULT0 + 8'h01, 16'hA501, "ch1 skipped");
    rd(mas_pkg::ADDR_CONV_CTRL, 16'h0070, "all off stop");
    $display("test disable stop done");
    // one channel, one-shot, each sample speed in turn
    wr(mas_pkg::ADDR_CH_DIS, 16'h00FE);
    for (int sp = 0; sp < 4; sp++) begin
      wr(mas_pkg::ADDR_CONV_CTRL, 16'h00C0 | 16'(sp * 16));
      convCnt = 0;
      cyc(1);
      while (adcActive === 1'b1 && convCnt < 300) begin
        convCnt++;
        cyc(1);
      end
      chk(16'(convCnt), 16'(convCyc[sp]) + 16'h0002, "conversion time");
    end
    $display("test speeds done");
    wrap_up();
  end
endmodule
`default_nettype wire
